// [core/repeater_tx_collision.sv]
`timescale 1ns/1ps
`default_nettype none
module repeater_tx_collision
    import rptr_pkg::*;
#(
    parameter int PORTS = NUM_PORTS
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // Carrier sense from each PHY (asynchronous pins)
    input wire logic [PORTS-1:0] crs,
    // Shared receive bus, already retimed to core_clk
    input wire logic rx_dv,
    input wire logic rx_er,
    input wire logic [NIBBLE_W-1:0] rxd,
    // Receive select per port
    output logic [PORTS-1:0] port_receive_select,
    // Shared transmit bus and per-port enables
    output logic [NIBBLE_W-1:0] txd,
    output logic tx_er,
    output logic [PORTS-1:0] tx_en,
    // Status
    output logic collision
);

    // Carrier sense synchroniser, three stages
    logic [PORTS-1:0] crs_s1, crs_s2, crs_s3, crs_q;
    logic [PORTS-1:0] next_crs_q;

    always_comb begin
        next_crs_q = crs_q;
        for (int i = 0; i < PORTS; i++) begin
            if (crs_s2[i] == crs_s3[i]) begin
                next_crs_q[i] = crs_s3[i];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            crs_s1 <= '0;
            crs_s2 <= '0;
            crs_s3 <= '0;
            crs_q <= '0;
        end else begin
            crs_s1 <= crs;
            crs_s2 <= crs_s1;
            crs_s3 <= crs_s2;
            crs_q <= next_crs_q;
        end
    end

    // Count active carriers
    logic [4:0] crs_count;
    logic [PORTS-1:0] lowest_crs;
    always_comb begin
        crs_count = 5'h00;
        lowest_crs = '0;
        for (int i = PORTS - 1; i >= 0; i--) begin
            crs_count = crs_count + {4'h0, crs_q[i]};
            if (crs_q[i]) begin
                lowest_crs = '0;
                lowest_crs[i] = 1'b1;
            end
        end
    end

    logic multi_crs;
    assign multi_crs = (crs_count >= 5'h02);

    rptr_state_t state, next_state;
    logic [PORTS-1:0] sel, next_sel;
    logic [PORTS-1:0] next_tx_en;
    logic [NIBBLE_W-1:0] next_txd;
    logic next_tx_er, next_collision;

    // Main control and transmit data path
    always_comb begin
        next_state = state;
        next_sel = sel;
        next_tx_en = '0;
        next_txd = TXD_RST;
        next_tx_er = 1'b0;
        next_collision = 1'b0;
        case (state)
            ST_IDLE: begin
                next_sel = '0;
                if (multi_crs) begin
                    next_state = ST_JAM;
                end else if (|crs_q) begin
                    next_sel = lowest_crs;
                    next_state = ST_REPEAT;
                end
            end
            ST_REPEAT: begin
                if (multi_crs) begin
                    next_sel = '0;
                    next_state = ST_JAM;
                end else if (!(|(crs_q & sel)) && !rx_dv) begin
                    next_sel = '0;
                    next_state = ST_IDLE;
                end else if (rx_dv) begin
                    // shared bus, all other ports enabled
                    next_tx_en = ~sel;
                    next_txd = rxd;
                    next_tx_er = rx_er;
                end
            end
            ST_JAM: begin
                next_sel = '0;
                next_tx_en = '1;
                next_txd = JAM_NIBBLE;
                next_collision = 1'b1;
                // hold while two or more carriers
                if (!multi_crs) begin
                    next_state = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                next_tx_en = '1;
                next_txd = JAM_NIBBLE;
                if (multi_crs) begin
                    next_state = ST_JAM;
                    next_collision = 1'b1;
                end else if (!(|crs_q)) begin
                    next_tx_en = '0;
                    next_txd = TXD_RST;
                    next_state = ST_IDLE;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_sel = '0;
            end
        endcase
    end

    // all transmit logic on the single core clock
    always_ff @(posedge core_clk) begin
        if (srst) begin
            state <= ST_IDLE;
            sel <= '0;
            tx_en <= '0;
            txd <= TXD_RST;
            tx_er <= 1'b0;
            collision <= 1'b0;
        end else begin
            state <= next_state;
            sel <= next_sel;
            tx_en <= next_tx_en;
            txd <= next_txd;
            tx_er <= next_tx_er;
            collision <= next_collision;
        end
    end

    assign port_receive_select = sel;

    AST_ONE_SELECT: assert property (@(posedge core_clk) disable iff (srst)
        $onehot0(port_receive_select))
        else $error("more than one receive select active");

    AST_COLLIDE_JAM: assert property (@(posedge core_clk) disable iff (srst)
        (state != ST_JAM && multi_crs) |=> ##1 (tx_en == '1 && txd == JAM_NIBBLE))
        else $error("collision not followed by jam");

    AST_JAM_ALL: assert property (@(posedge core_clk) disable iff (srst)
        collision |-> (tx_en == '1 && txd == JAM_NIBBLE && tx_er == 1'b0))
        else $error("jam not sent on all ports");

    AST_ERR_PROP: assert property (@(posedge core_clk) disable iff (srst)
        (state == ST_REPEAT && rx_dv && rx_er && multi_crs == 1'b0
            && (|(crs_q & sel))) |=> tx_er)
        else $error("receive error not repeated");

    AST_SEL_CARRIER: assert property (@(posedge core_clk) disable iff (srst)
        (state == ST_IDLE && !multi_crs && |crs_q) |=> (sel == $past(lowest_crs)))
        else $error("carrier port not selected");

    AST_BUS_SHARED: assert property (@(posedge core_clk) disable iff (srst)
        (|tx_en && !collision && state == ST_REPEAT) |-> ((tx_en & sel) == '0))
        else $error("source port enabled for transmit");

    AST_HOLD_COL: assert property (@(posedge core_clk) disable iff (srst)
        (state == ST_JAM && multi_crs) |=> state == ST_JAM)
        else $error("collision dropped with two carriers");

    AST_IDLE_QUIET: assert property (@(posedge core_clk) disable iff (srst)
        (state == ST_DRAIN && !multi_crs && !(|crs_q)) |=> ##1 (tx_en == '0))
        else $error("enables stay after drain");

    AST_SYNC_CRS: assert property (@(posedge core_clk) disable iff (srst)
        (crs_s2 == crs_s3) |=> (crs_q == $past(crs_s3)))
        else $error("carrier filter wrong");

    AST_REPEAT_DATA: assert property (@(posedge core_clk) disable iff (srst)
        (state == ST_REPEAT && rx_dv && !multi_crs)
            |=> (tx_en == ~$past(sel) && txd == $past(rxd)))
        else $error("received nibble not repeated to other ports");

    AST_JAM_NO_SELECT: assert property (@(posedge core_clk) disable iff (srst)
        (state == ST_JAM) |-> (port_receive_select == '0))
        else $error("receive select active during collision");

endmodule
`default_nettype wire

// [common/rptr_pkg.sv]
`default_nettype none
package rptr_pkg;
    // Port count and nibble width
    localparam int NUM_PORTS = 12;
    localparam int NIBBLE_W = 4;
    // Reference and core clocks in MHz
    localparam int REF_CLK_MHZ = 25;
    localparam int CORE_CLK_MHZ = 125;
    // Jam nibble pattern (alternating ones and zeros)
    localparam logic [3:0] JAM_NIBBLE = 4'h5;
    // Reset values
    localparam logic [3:0] TXD_RST = 4'h0;
    // Controller states, one-hot
    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_REPEAT = 4'h2,
        ST_JAM = 4'h4,
        ST_DRAIN = 4'h8
    } rptr_state_t;
endpackage
`default_nettype wire

// [testbench/phy_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module phy_partner
    import rptr_pkg::*;
#(
    parameter bit REPEATER_ROLE = 1'b1
) (
    // Shared reference clock, on the reference input
    input wire logic core_clk,
    // same reference on the oscillator input
    input wire logic phy_oscillator_clock_input,
    // Receive selects and transmit enables from controller
    input wire logic [NUM_PORTS-1:0] sel,
    input wire logic [NUM_PORTS-1:0] tx_en,
    // Carrier and shared receive bus
    output logic [NUM_PORTS-1:0] crs,
    output logic rx_dv,
    output logic rx_er,
    output logic [NIBBLE_W-1:0] rxd
);
    logic [NUM_PORTS-1:0] crs_rx;
    logic [NIBBLE_W-1:0] last;
    initial begin
        crs_rx = '0;
        rx_dv = 1'b0;
        rx_er = 1'b0;
        rxd = '0;
        last = '0;
    end
    // node role also raises carrier while transmitting
    assign crs = REPEATER_ROLE ? crs_rx : (crs_rx | tx_en);
    // Released bus shows stale data inverted
    always @(posedge phy_oscillator_clock_input) begin
        if (sel == '0) rxd <= ~last;
    end
    task automatic carrier(input int port, input logic on);
        @(posedge core_clk);
        crs_rx[port] <= on;
    endtask
    // two ports receiving from the same edge
    task automatic carrier_pair(input int a, input int b, input logic on);
        @(posedge core_clk);
        crs_rx[a] <= on;
        crs_rx[b] <= on;
    endtask
    task automatic nibble(input logic [3:0] d, input logic e, input logic v);
        @(posedge core_clk);
        rxd <= d;
        last <= d;
        rx_er <= e;
        rx_dv <= v;
    endtask
endmodule
`default_nettype wire

// [testbench/repeater_tx_collision_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module repeater_tx_collision_tb;
    import rptr_pkg::*;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic [NUM_PORTS-1:0] crs, sel, tx_en;
    logic rx_dv, rx_er, tx_er, collision;
    logic [NIBBLE_W-1:0] rxd, txd;
    logic [16:0] notes[$];
    int err_total = 0;
    int n_compared = 0;
    int seed = 64888;
    // 125 MHz clock
    always #4 core_clk = ~core_clk;
    phy_partner u_phy_partner(.core_clk(core_clk), .phy_oscillator_clock_input(core_clk),
        .sel(sel), .tx_en(tx_en), .crs(crs), .rx_dv(rx_dv), .rx_er(rx_er), .rxd(rxd));
    repeater_tx_collision u_repeater_tx_collision(.core_clk(core_clk), .srst(srst), .crs(crs),
        .rx_dv(rx_dv), .rx_er(rx_er), .rxd(rxd), .port_receive_select(sel), .txd(txd),
        .tx_er(tx_er), .tx_en(tx_en), .collision(collision));
    task automatic check(input string what, input logic [16:0] seen, input logic [16:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic close_out();
        if (err_total == 0 && n_compared > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // Output watcher against queued notes
    always @(posedge core_clk) begin
        if (!srst) begin
            check("select onehot", 17'($onehot0(sel)), 17'h1);
            if (collision === 1'b1) check("jam", {tx_en, txd, tx_er}, {12'hfff, JAM_NIBBLE, 1'b0});
            else if (tx_en !== '0 && notes.size() > 0) check("repeat", {tx_en, txd, tx_er}, notes.pop_front());
        end
    end
    // One packet with random nibbles and errors
    task automatic packet(input int p);
        logic [3:0] d;
        logic e;
        u_phy_partner.carrier(p, 1'b1);
        for (int i = 0; i < 20 && sel !== 12'h1 << p; i++) @(posedge core_clk);
        check("select", 17'(sel), 17'(12'h1 << p));
        for (int i = 0; i < 8; i++) begin
            d = 4'($random(seed));
            e = 1'($random(seed));
            notes.push_back({~(12'h1 << p), d, e});
            u_phy_partner.nibble(d, e, 1'b1);
        end
        u_phy_partner.nibble(4'h0, 1'b0, 1'b0);
        u_phy_partner.carrier(p, 1'b0);
        repeat (10) @(posedge core_clk);
        check("notes drained", 17'(notes.size()), 17'h0);
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge core_clk);
        srst <= 1'b0;
        for (int p = 0; p < NUM_PORTS; p += 5) packet(p);
        u_phy_partner.carrier(3, 1'b1);
        repeat (8) @(posedge core_clk);
        u_phy_partner.carrier(8, 1'b1);
        for (int i = 0; i < 20 && collision !== 1'b1; i++) @(posedge core_clk);
        check("collision", 17'(collision), 17'h1);
        u_phy_partner.carrier(3, 1'b0);
        repeat (8) @(posedge core_clk);
        check("jam tail", {collision, tx_en}, 17'h0fff);
        u_phy_partner.carrier(8, 1'b0);
        repeat (8) @(posedge core_clk);
        check("idle", {collision, tx_en}, 17'h0);
        // Two carriers at once, then a fresh collision in the jam tail
        u_phy_partner.carrier_pair(2, 7, 1'b1);
        for (int i = 0; i < 20 && collision !== 1'b1; i++) @(posedge core_clk);
        check("joint collision", 17'(collision), 17'h1);
        check("select cleared", 17'(sel), 17'h0);
        u_phy_partner.carrier(2, 1'b0);
        repeat (8) @(posedge core_clk);
        check("pair jam tail", {collision, tx_en}, 17'h0fff);
        u_phy_partner.carrier(2, 1'b1);
        for (int i = 0; i < 20 && collision !== 1'b1; i++) @(posedge core_clk);
        check("second collision", 17'(collision), 17'h1);
        u_phy_partner.carrier_pair(2, 7, 1'b0);
        repeat (10) @(posedge core_clk);
        check("pair idle", {collision, tx_en}, 17'h0);
        packet(11);
        close_out();
    end
    // Watchdog
    initial begin
        repeat (5000) @(posedge core_clk);
        err_total++;
        close_out();
    end
endmodule
`default_nettype wire
